// ---- common/usbirq_defines.svh ----
// register offsets, field positions, reset values and timing for the usb irq block
`ifndef USBIRQ_DEFINES_SVH
`define USBIRQ_DEFINES_SVH
`define USBIRQ_OFS_FLAG     4'h0
`define USBIRQ_OFS_ENABLE   4'h4
`define USBIRQ_OFS_CTRL     4'h8
`define USBIRQ_OFS_ADDR     4'hC
`define USBIRQ_IDX_FLAG     2'h0
`define USBIRQ_IDX_ENABLE   2'h1
`define USBIRQ_IDX_CTRL     2'h2
`define USBIRQ_IDX_ADDR     2'h3
`define USBIRQ_OFS_STAT     5'h10
`define USBIRQ_B_GOOD       7
`define USBIRQ_B_SETUP      5
`define USBIRQ_B_ERR        4
`define USBIRQ_B_SLEEP      3
`define USBIRQ_B_WAKE       2
`define USBIRQ_B_RESET      1
`define USBIRQ_B_SOF        0
`define USBIRQ_FLAG_MASK    8'hBF
`define USBIRQ_B_WSEEN      7
`define USBIRQ_B_RSEEN      6
`define USBIRQ_B_RESUME     3
`define USBIRQ_B_REGULATOR_OFF       2
`define USBIRQ_B_FSLEEP     1
`define USBIRQ_B_FRESET     0
`define USBIRQ_CTRL_RESET   4'h6
`define USBIRQ_ERR_NONE     3'h0
`define USBIRQ_PID_LOW      2'h1
`define USBIRQ_PID_SETUP    2'h3
`define USBIRQ_IDLE_MS      3
`define USBIRQ_CLK_KHZ      100000
`endif

// ---- common/usbirq_pkg.sv ----
// types shared by the usb irq block
package usbirq_pkg;
	typedef enum logic [1:0] {
		USBIRQ_ACTIVE  = 2'h0,
		USBIRQ_SLEEP   = 2'h1,
		USBIRQ_RESUME  = 2'h3
	} usbirq_state_t;
endpackage

// ---- rtl/usbirq_top.sv ----
// interrupt, control, address and status registers of the usb link
`timescale 1ns/1ps
`include "usbirq_defines.svh"

// Summary of operation
// - flags set only by hardware events; software writes only clear them
// - good transfer flag is OR of endpoint done flags, not clearable here
// - only error-free acknowledged transfers count as good
// - setup while control pipe done still set flags collision, status held
// - any bus error sets the error flag
// - more than 3 ms constant idle sets the sleep flag
// - idle check on after bus reset, off from forced sleep to resume end
// - activity during suspend sets wake flag, on its own wake output
// - bus reset sets reset flag and clears address and endpoint controls
// - each received frame start token sets the frame flag
// - interrupt when flag and enable set and cpu mask clear
// - control register shows resume seen and reset seen, read only
// - resume bit forces resume signalling until software clears it
// - power-down bit switches the transceiver regulator off
// - control register resets to 06h: regulator off, forced suspend
// - forced sleep bit entered by software, cleared by bus activity
// - forced reset holds link in reset; release raises reset flag
// - seven bit device address, top bit zero, cleared by usb reset
// - last control pipe token upper bits reported, low bits fixed 01
// - direction and endpoint number recorded on endpoint transfers
// - error code loaded on error, cleared when error flag cleared
module usbirq_top #(
	parameter int IDLE_CYCLES = (`USBIRQ_IDLE_MS * `USBIRQ_CLK_KHZ)
) (
	input  wire logic       clk_i,           // system clock
	input  wire logic       rst_i,           // synchronous reset
	input  wire logic       wb_cyc_i,        // wishbone cycle
	input  wire logic       wb_stb_i,        // wishbone strobe
	input  wire logic       wb_we_i,         // wishbone write
	input  wire logic [4:0] wb_adr_i,        // byte address
	input  wire logic [3:0] wb_sel_i,        // byte enables
	input  wire logic [31:0] wb_dat_i,       // write data
	output logic      [31:0] wb_dat_o,       // read data
	output logic            wb_ack_o,        // acknowledge
	input  wire logic       xfer_ok_i,       // good transfer finished
	input  wire logic       xfer_nak_i,      // answered with nak or stall
	input  wire logic [1:0] xfer_ep_i,       // endpoint of transfer
	input  wire logic       xfer_in_i,       // transfer direction in
	input  wire logic [1:0] xfer_pid_i,      // token upper pid bits
	input  wire logic [2:0] ep_done_i,       // endpoint done flags
	input  wire logic       err_i,           // bus error pulse
	input  wire logic [2:0] err_code_i,      // error kind
	input  wire logic       bus_idle_i,      // bus lines idle
	input  wire logic       bus_active_i,    // activity seen
	input  wire logic       bus_resume_i,    // resume seen on bus
	input  wire logic       bus_reset_i,     // reset sequence on bus
	input  wire logic       sof_i,           // frame start token
	input  wire logic       cpu_mask_i,      // cpu interrupt mask
	output logic            irq_o,           // main interrupt
	output logic            wake_irq_o,      // wake interrupt vector
	output logic            link_reset_o,    // endpoint reset
	output logic            resume_drive_o,  // drive resume on bus
	output logic            regulator_off_o, // regulator off
	output logic            suspend_o,       // link in suspend
	output logic [6:0]      dev_addr_o       // device address
);

	logic [7:0] irq_flag_reg_r;
	logic [7:0] irq_enable_reg_r;
	logic [3:0] link_control_reg_r;
	logic [6:0] device_addr_reg_r;
	logic [1:0] token_upper_bits_r;
	logic       dir_in_r;
	logic [1:0] endpoint_id_r;
	logic [2:0] err_code_r;
	logic       wake_seen_r;
	logic       reset_seen_r;
	logic       idle_en_r;
	logic       freset_q_r;
	logic [31:0] idle_cnt_r;
	usbirq_pkg::usbirq_state_t state_r;

	logic       wr_stb;
	logic       wr_flag;
	logic       wr_ctrl;
	logic       any_reset;
	logic       reset_done;
	logic       good_xfer;
	logic       setup_clash;
	logic       idle_hit;
	logic       wake_evt;
	logic [7:0] flag_view;
	logic [7:0] ctrl_view;
	logic [7:0] stat_view;
	logic [7:0] flag_nxt;

	// bus decode, one-cycle write strobe
	assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
	assign wr_flag = wr_stb & (wb_adr_i == {1'b0, `USBIRQ_OFS_FLAG});
	assign wr_ctrl = wr_stb & (wb_adr_i == {1'b0, `USBIRQ_OFS_CTRL});

	// link reset while forced or seen on the bus
	assign any_reset = bus_reset_i | link_control_reg_r[`USBIRQ_B_FRESET];
	assign reset_done = freset_q_r & ~link_control_reg_r[`USBIRQ_B_FRESET];

	// event qualification
	assign good_xfer = xfer_ok_i & ~xfer_nak_i;
	assign setup_clash = good_xfer & (xfer_ep_i == 2'h0) & ep_done_i[0]
		& (xfer_pid_i == `USBIRQ_PID_SETUP);
	assign idle_hit = idle_en_r & (idle_cnt_r == IDLE_CYCLES);
	assign wake_evt = (state_r == usbirq_pkg::USBIRQ_SLEEP) & bus_active_i;

	// read views
	assign flag_view = {|ep_done_i, 1'b0, irq_flag_reg_r[5:0]};
	assign ctrl_view = {wake_seen_r, reset_seen_r, 2'h0,
		link_control_reg_r};
	assign stat_view = {token_upper_bits_r, dir_in_r, endpoint_id_r,
		err_code_r};

	// next flag value: set wins over clear
	always_comb begin
		flag_nxt = irq_flag_reg_r;
		if (wr_flag) begin
			flag_nxt = irq_flag_reg_r & wb_dat_i[7:0];
		end
		if (setup_clash) begin
			flag_nxt[`USBIRQ_B_SETUP] = 1'b1;
		end
		if (err_i) begin
			flag_nxt[`USBIRQ_B_ERR] = 1'b1;
		end
		if (idle_hit) begin
			flag_nxt[`USBIRQ_B_SLEEP] = 1'b1;
		end
		if (wake_evt) begin
			flag_nxt[`USBIRQ_B_WAKE] = 1'b1;
		end
		if (bus_reset_i | reset_done) begin
			flag_nxt[`USBIRQ_B_RESET] = 1'b1;
		end
		if (sof_i) begin
			flag_nxt[`USBIRQ_B_SOF] = 1'b1;
		end
		flag_nxt = flag_nxt & `USBIRQ_FLAG_MASK & 8'h7F;
	end

	// interrupt flag register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_flag_reg_r <= 8'h00;
		end else begin
			irq_flag_reg_r <= flag_nxt;
		end
	end

	// interrupt enable register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_enable_reg_r <= 8'h00;
		end else if (wr_stb && wb_adr_i == {1'b0, `USBIRQ_OFS_ENABLE}) begin
			irq_enable_reg_r <= wb_dat_i[7:0] & `USBIRQ_FLAG_MASK;
		end
	end

	// control register, hardware clears forced sleep on activity
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link_control_reg_r <= `USBIRQ_CTRL_RESET;
		end else begin
			if (wr_ctrl) begin
				link_control_reg_r <= wb_dat_i[3:0];
			end
			if (bus_active_i && link_control_reg_r[`USBIRQ_B_FSLEEP]) begin
				link_control_reg_r[`USBIRQ_B_FSLEEP] <= 1'b0;
			end
		end
	end

	// previous forced reset for release edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			freset_q_r <= 1'b0;
		end else begin
			freset_q_r <= link_control_reg_r[`USBIRQ_B_FRESET];
		end
	end

	// resume and reset seen indicators
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_seen_r <= 1'b0;
			reset_seen_r <= 1'b0;
		end else if (state_r == usbirq_pkg::USBIRQ_SLEEP) begin
			if (bus_resume_i) begin
				wake_seen_r <= 1'b1;
			end
			if (bus_reset_i) begin
				reset_seen_r <= 1'b1;
			end
		end else if (state_r == usbirq_pkg::USBIRQ_ACTIVE) begin
			wake_seen_r <= 1'b0;
			reset_seen_r <= 1'b0;
		end
	end

	// suspend state: sleep, resume, active
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= usbirq_pkg::USBIRQ_SLEEP;
		end else begin
			case (state_r)
			usbirq_pkg::USBIRQ_ACTIVE: begin
				if (idle_hit || link_control_reg_r[`USBIRQ_B_FSLEEP]) begin
					state_r <= usbirq_pkg::USBIRQ_SLEEP;
				end
			end
			usbirq_pkg::USBIRQ_SLEEP: begin
				if (bus_active_i || any_reset) begin
					state_r <= usbirq_pkg::USBIRQ_RESUME;
				end
			end
			usbirq_pkg::USBIRQ_RESUME: begin
				if (bus_idle_i && !link_control_reg_r[`USBIRQ_B_RESUME]) begin
					state_r <= usbirq_pkg::USBIRQ_ACTIVE;
				end
			end
			default: begin
				state_r <= usbirq_pkg::USBIRQ_SLEEP;
			end
			endcase
		end
	end

	// idle check enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idle_en_r <= 1'b0;
		end else if (any_reset) begin
			idle_en_r <= 1'b1;
		end else if (link_control_reg_r[`USBIRQ_B_FSLEEP] || idle_hit) begin
			idle_en_r <= 1'b0;
		end else if (state_r == usbirq_pkg::USBIRQ_RESUME && bus_idle_i) begin
			idle_en_r <= 1'b1;
		end
	end

	// idle counter, saturates at the limit
	always_ff @(posedge clk_i) begin
		if (rst_i || !bus_idle_i || !idle_en_r) begin
			idle_cnt_r <= 32'h0;
		end else if (idle_cnt_r != IDLE_CYCLES) begin
			idle_cnt_r <= idle_cnt_r + 32'h1;
		end
	end

	// device address
	always_ff @(posedge clk_i) begin
		if (rst_i || any_reset) begin
			device_addr_reg_r <= 7'h00;
		end else if (wr_stb && wb_adr_i == {1'b0, `USBIRQ_OFS_ADDR}) begin
			device_addr_reg_r <= wb_dat_i[6:0];
		end
	end

	// transfer status fields
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			token_upper_bits_r <= 2'h0;
			dir_in_r <= 1'b0;
			endpoint_id_r <= 2'h0;
		end else if (good_xfer && !setup_clash) begin
			endpoint_id_r <= xfer_ep_i;
			if (xfer_ep_i == 2'h0) begin
				token_upper_bits_r <= xfer_pid_i;
			end else begin
				dir_in_r <= xfer_in_i;
			end
		end
	end

	// error code, cleared with the error flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			err_code_r <= `USBIRQ_ERR_NONE;
		end else if (err_i) begin
			err_code_r <= err_code_i;
		end else if (!flag_nxt[`USBIRQ_B_ERR]) begin
			err_code_r <= `USBIRQ_ERR_NONE;
		end
	end

	// wishbone answer one cycle after request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			case (wb_adr_i)
			{1'b0, `USBIRQ_OFS_FLAG}:   wb_dat_o <= {24'h0, flag_view};
			{1'b0, `USBIRQ_OFS_ENABLE}: wb_dat_o <= {24'h0, irq_enable_reg_r};
			{1'b0, `USBIRQ_OFS_CTRL}:   wb_dat_o <= {24'h0, ctrl_view};
			{1'b0, `USBIRQ_OFS_ADDR}:   wb_dat_o <= {25'h0, device_addr_reg_r};
			`USBIRQ_OFS_STAT:           wb_dat_o <= {24'h0, stat_view};
			default:                    wb_dat_o <= 32'h0;
			endcase
		end
	end

	// registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
			wake_irq_o <= 1'b0;
			link_reset_o <= 1'b0;
			resume_drive_o <= 1'b0;
			regulator_off_o <= 1'b1;
			suspend_o <= 1'b1;
			dev_addr_o <= 7'h00;
		end else begin
			irq_o <= ~cpu_mask_i & |(flag_nxt & irq_enable_reg_r
				& ~(8'h1 << `USBIRQ_B_WAKE)
				| ({|ep_done_i, 7'h0} & irq_enable_reg_r));
			wake_irq_o <= ~cpu_mask_i & flag_nxt[`USBIRQ_B_WAKE]
				& irq_enable_reg_r[`USBIRQ_B_WAKE];
			link_reset_o <= any_reset;
			resume_drive_o <= link_control_reg_r[`USBIRQ_B_RESUME];
			regulator_off_o <= link_control_reg_r[`USBIRQ_B_REGULATOR_OFF];
			suspend_o <= (state_r == usbirq_pkg::USBIRQ_SLEEP);
			dev_addr_o <= device_addr_reg_r;
		end
	end

	// assertions
	sequence reset_release_s;
		freset_q_r && !link_control_reg_r[`USBIRQ_B_FRESET];
	endsequence

	flag_no_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_flag && !err_i) |=> !($rose(irq_flag_reg_r[`USBIRQ_B_ERR])))
		else $error("software set error flag");
	// a flag read returns the endpoint done or in bit 7
	good_or_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o
		&& wb_adr_i == {1'b0, `USBIRQ_OFS_FLAG})
		|=> wb_dat_o[`USBIRQ_B_GOOD] == $past(|ep_done_i))
		else $error("good flag not endpoint or");
	err_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		err_i |=> irq_flag_reg_r[`USBIRQ_B_ERR] && err_code_r == $past(err_code_i))
		else $error("error not recorded");
	sof_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sof_i |=> irq_flag_reg_r[`USBIRQ_B_SOF])
		else $error("frame flag missing");
	addr_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		any_reset |=> device_addr_reg_r == 7'h00 ##1 dev_addr_o == 7'h00)
		else $error("address not cleared");
	freset_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
		reset_release_s |=> irq_flag_reg_r[`USBIRQ_B_RESET])
		else $error("forced reset release lost");
	clash_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		setup_clash |=> $stable(endpoint_id_r) && irq_flag_reg_r[`USBIRQ_B_SETUP])
		else $error("setup collision wrong");
	resume_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
		link_control_reg_r[`USBIRQ_B_RESUME] |=> resume_drive_o)
		else $error("resume not driven");
	fsleep_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(bus_active_i && !wr_ctrl) |=> !link_control_reg_r[`USBIRQ_B_FSLEEP])
		else $error("forced sleep kept");
	// idle and wake events reach their flags
	idle_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		idle_hit |=> irq_flag_reg_r[`USBIRQ_B_SLEEP])
		else $error("idle flag missing");
	wake_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wake_evt |=> irq_flag_reg_r[`USBIRQ_B_WAKE])
		else $error("wake flag missing");
	// forced sleep keeps the idle check off unless a reset re-arms it
	idle_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(link_control_reg_r[`USBIRQ_B_FSLEEP] && !any_reset)
		|=> !idle_en_r)
		else $error("idle check left on");

endmodule

// ---- tb/usbirq_host.sv ----
// behavioural usb host side driving the bus event lines
`timescale 1ns/1ps
module usbirq_host (
	input  wire logic       clk_i,  // system clock
	output logic            ok_o,   // good transfer pulse
	output logic            nak_o,  // nak or stall with it
	output logic [1:0]      ep_o,   // endpoint
	output logic            in_o,   // direction in
	output logic [1:0]      pid_o,  // token upper bits
	output logic [2:0]      done_o, // endpoint done flags
	output logic            err_o,  // bus error pulse
	output logic [2:0]      code_o, // error kind
	output logic [3:0]      lvl_o   // idle, activity, resume, reset
);
	// lines quiet at start
	initial begin
		{ok_o, nak_o, ep_o, in_o, pid_o, done_o} = '0;
		{err_o, code_o, lvl_o} = '0;
	end
	// one transfer; qualifiers scrambled once the pulse is over
	task automatic xfer(input [1:0] e, input i, input [1:0] p, input n);
		@(posedge clk_i);
		{ep_o, in_o, pid_o, nak_o, ok_o} <= {e, i, p, n, 1'b1};
		@(posedge clk_i);
		{ep_o, in_o, pid_o, nak_o, ok_o} <= {~e, ~i, ~p, 2'b00};
	endtask
	// one bus error with its kind
	task automatic fault(input [2:0] c);
		@(posedge clk_i);
		{err_o, code_o} <= {1'b1, c};
		@(posedge clk_i);
		{err_o, code_o} <= {1'b0, ~c};
	endtask
	// endpoint flags and bus line levels
	task automatic lvl(input [2:0] d, input [3:0] v);
		@(posedge clk_i);
		{done_o, lvl_o} <= {d, v};
	endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the usb irq register block
`timescale 1ns/1ps
`include "usbirq_defines.svh"
module testbench;
	localparam int IDLE = 20;
	localparam logic [4:0] FL = {1'b0, `USBIRQ_OFS_FLAG};
	localparam logic [4:0] EN = {1'b0, `USBIRQ_OFS_ENABLE};
	localparam logic [4:0] CT = {1'b0, `USBIRQ_OFS_CTRL};
	localparam logic [4:0] AD = {1'b0, `USBIRQ_OFS_ADDR};
	localparam logic [4:0] ST = `USBIRQ_OFS_STAT;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, mask = 1'b0;
	logic [4:0]  adr = '0;
	logic [31:0] wdat = '0;
	logic [31:0] rdat;
	logic        ack, irq, wirq, lrst, rdrv, roff, bus_idle_sleep_flag, ok, nak, in, err;
	logic [6:0]  addr;
	logic [1:0]  ep, pid;
	logic [2:0]  done, code;
	logic [3:0]  lv;
	logic [7:0]  q;
	logic [2:0]  codes [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
	logic [1:0]  pids [3] = '{2'h0, 2'h3, 2'h2};
	int          n_fail = 0, n_checks = 0;
	// frame start pulses come from the bench directly
	logic        sof = 1'b0;

	usbirq_top #(.IDLE_CYCLES(IDLE)) i_usbirq_top (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .xfer_ok_i(ok), .xfer_nak_i(nak), .xfer_ep_i(ep),
		.xfer_in_i(in), .xfer_pid_i(pid), .ep_done_i(done), .err_i(err),
		.err_code_i(code), .bus_idle_i(lv[3]), .bus_active_i(lv[2]),
		.bus_resume_i(lv[1]), .bus_reset_i(lv[0]), .sof_i(sof),
		.cpu_mask_i(mask), .irq_o(irq), .wake_irq_o(wirq),
		.link_reset_o(lrst), .resume_drive_o(rdrv),
		.regulator_off_o(roff), .suspend_o(bus_idle_sleep_flag), .dev_addr_o(addr));
	usbirq_host i_usbirq_host (.clk_i(clk_i), .ok_o(ok), .nak_o(nak),
		.ep_o(ep), .in_o(in), .pid_o(pid), .done_o(done), .err_o(err),
		.code_o(code), .lvl_o(lv));

	// 100 MHz clock
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic close_out();
		if (n_fail == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk8(input [7:0] got, input [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input got, input exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one classic wishbone cycle, byte in the low lane
	task automatic wb(input [4:0] a, input w, input [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) n_fail++;
		q = rdat[7:0];
		{cyc, stb, we} <= 3'b000;
	endtask
	task automatic rd(input [4:0] a, input [7:0] m, input [7:0] e);
		wb(a, 1'b0, 8'h00);
		chk8(q & m, e);
	endtask
	task automatic st(input int c);
		repeat (c) @(negedge clk_i);
	endtask
	// one idle edge to leave resume, then forced sleep
	task automatic nap();
		i_usbirq_host.lvl(3'h0, 4'h8);
		i_usbirq_host.lvl(3'h0, 4'h0);
		wb(CT, 1'b1, 8'h02);
	endtask

	// watchdog
	initial begin
		#200000;
		n_fail++;
		close_out();
	end
	// main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(FL, 8'hFF, 8'h00);
		rd(EN, 8'hFF, 8'h00);
		rd(CT, 8'hFF, 8'h06);
		rd(AD, 8'hFF, 8'h00);
		rd(ST, 8'hFF, 8'h00);
		chk1(roff, 1'b1);
		chk1(bus_idle_sleep_flag, 1'b1);
		wb(FL, 1'b1, 8'hFF);
		rd(FL, 8'hFF, 8'h00);
		// wake from the reset-time suspend
		i_usbirq_host.lvl(3'h0, 4'h4);
		i_usbirq_host.lvl(3'h0, 4'h0);
		st(3);
		rd(FL, 8'hFF, 8'h04);
		rd(CT, 8'h0F, 8'h04);
		chk1(bus_idle_sleep_flag, 1'b0);
		wb(EN, 1'b1, 8'h04);
		st(3);
		chk1(wirq, 1'b1);
		chk1(irq, 1'b0);
		wb(FL, 1'b1, 8'hFB);
		st(3);
		chk1(wirq, 1'b0);
		wb(CT, 1'b1, 8'h00);
		st(2);
		chk1(roff, 1'b0);
		repeat (300) @(posedge clk_i);
		wb(CT, 1'b1, 8'h08);
		st(2);
		chk1(rdrv, 1'b1);
		wb(CT, 1'b1, 8'h00);
		st(2);
		chk1(rdrv, 1'b0);
		// frame start with and without cpu mask
		wb(EN, 1'b1, 8'h01);
		@(posedge clk_i) sof <= 1'b1;
		@(posedge clk_i) sof <= 1'b0;
		st(3);
		rd(FL, 8'hFF, 8'h01);
		chk1(irq, 1'b1);
		@(posedge clk_i) mask <= 1'b1;
		st(3);
		chk1(irq, 1'b0);
		@(posedge clk_i) mask <= 1'b0;
		wb(FL, 1'b1, 8'hFE);
		rd(FL, 8'hFF, 8'h00);
		// error kinds 1 to 5 and 7, code cleared with its flag
		foreach (codes[i]) begin
			i_usbirq_host.fault(codes[i]);
			rd(FL, 8'hFF, 8'h10);
			rd(ST, 8'hFF, {5'h00, codes[i]});
			wb(FL, 1'b1, 8'hEF);
			rd(ST, 8'h07, 8'h00);
		end
		chk1(irq, 1'b0);
		// good transfer flag follows the endpoint flags
		i_usbirq_host.lvl(3'h4, 4'h0);
		rd(FL, 8'hFF, 8'h80);
		wb(FL, 1'b1, 8'h00);
		rd(FL, 8'hFF, 8'h80);
		i_usbirq_host.lvl(3'h0, 4'h0);
		rd(FL, 8'hFF, 8'h00);
		i_usbirq_host.xfer(2'h2, 1'b1, 2'h0, 1'b0);
		rd(ST, 8'h38, 8'h30);
		i_usbirq_host.xfer(2'h1, 1'b0, 2'h0, 1'b1);
		rd(ST, 8'h38, 8'h30);
		i_usbirq_host.xfer(2'h1, 1'b0, 2'h0, 1'b0);
		rd(ST, 8'h38, 8'h08);
		foreach (pids[i]) begin
			i_usbirq_host.xfer(2'h0, 1'b0, pids[i], 1'b0);
			rd(ST, 8'hC0, {pids[i], 6'h00});
		end
		// setup while control pipe still done
		i_usbirq_host.lvl(3'h1, 4'h0);
		i_usbirq_host.xfer(2'h0, 1'b0, 2'h3, 1'b0);
		rd(FL, 8'h20, 8'h20);
		rd(ST, 8'hC0, 8'h80);
		i_usbirq_host.lvl(3'h0, 4'h0);
		wb(FL, 1'b1, 8'hDF);
		rd(FL, 8'hFF, 8'h00);
		// address, bus reset, resume seen
		wb(AD, 1'b1, 8'hFF);
		rd(AD, 8'hFF, 8'h7F);
		chk8({1'b0, addr}, 8'h7F);
		nap();
		i_usbirq_host.lvl(3'h0, 4'h5);
		st(4);
		chk1(lrst, 1'b1);
		rd(CT, 8'h40, 8'h40);
		i_usbirq_host.lvl(3'h0, 4'h0);
		st(2);
		rd(AD, 8'hFF, 8'h00);
		rd(FL, 8'h02, 8'h02);
		wb(FL, 1'b1, 8'hF9);
		nap();
		i_usbirq_host.lvl(3'h0, 4'h6);
		st(3);
		rd(CT, 8'hC0, 8'h80);
		i_usbirq_host.lvl(3'h0, 4'h0);
		// forced reset
		wb(AD, 1'b1, 8'h12);
		wb(CT, 1'b1, 8'h01);
		st(2);
		chk1(lrst, 1'b1);
		wb(CT, 1'b1, 8'h00);
		st(2);
		rd(FL, 8'h02, 8'h02);
		rd(AD, 8'hFF, 8'h00);
		wb(FL, 1'b1, 8'hFD);
		// idle detection raises the sleep flag
		i_usbirq_host.lvl(3'h0, 4'h8);
		st(IDLE - 8);
		rd(FL, 8'h08, 8'h00);
		st(12);
		rd(FL, 8'h08, 8'h08);
		i_usbirq_host.lvl(3'h0, 4'h0);
		wb(FL, 1'b1, 8'hF7);
		// bus reset re-arms the idle check, forced sleep must stop it
		i_usbirq_host.lvl(3'h0, 4'h1);
		i_usbirq_host.lvl(3'h0, 4'h0);
		wb(CT, 1'b1, 8'h02);
		i_usbirq_host.lvl(3'h0, 4'h8);
		st(IDLE + 10);
		rd(FL, 8'h08, 8'h00);
		chk1(bus_idle_sleep_flag, 1'b1);
		rd(5'h14, 8'hFF, 8'h00);
		close_out();
	end
endmodule
